/* File: core/scsp_pkg.sv */
// Purpose: Shared constants and types of the serial configuration slave port
// Assumes: 125 MHz core clock; serial clock driven by the bus master
// Notes:   Bank and EEPROM image are 20 bytes each, held in flip-flops

package scsp_pkg;

   localparam logic [3:0] DEV_TYPE_CODE   = 4'hA;
   localparam logic [7:0] REG_FIRST       = 8'h00;
   localparam logic [7:0] REG_LAST        = 8'h13;
   localparam logic [7:0] EE_FIRST        = 8'h20;
   localparam logic [7:0] EE_LAST         = 8'h33;
   localparam logic [7:0] CMD_BLK_WRITE   = 8'h83;
   localparam logic [7:0] CMD_BLK_PREP    = 8'hC0;
   localparam logic [7:0] CMD_BLK_READ    = 8'hC1;
   localparam logic [7:0] CMD_REBOOT      = 8'hC4;
   localparam logic [7:0] BLK_READ_COUNT  = 8'h10;
   localparam logic [7:0] BLK_MIN         = 8'h01;
   localparam logic [7:0] BLK_MAX         = 8'h10;
   localparam int         BANK_DEPTH      = 20;
   localparam int         LOCK_BIT        = 0;
   localparam logic [7:0] BANK_RESET      = 8'h00;
   localparam logic [3:0] BIT_ACK         = 4'h8;
   localparam logic [3:0] BIT_LAST_DATA   = 4'h7;
   localparam logic [3:0] SLAVE_ADDR_BIT3 = 4'h3;

   localparam longint     CLK_PERIOD_PS   = 8000;
   localparam longint     EE_WRITE_US     = 11000;
   localparam int         EE_WRITE_CYCLES = int'((EE_WRITE_US * 1000 * 1000) / CLK_PERIOD_PS);
   localparam int         EE_CNT_W        = 21;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_ADDR   = 4'h1,
      ST_CMD    = 4'h2,
      ST_DATA1  = 4'h3,
      ST_DATA2  = 4'h4,
      ST_BCNT   = 4'h5,
      ST_BDATA  = 4'h6,
      ST_RDCNT  = 4'h7,
      ST_RDDATA = 4'h8,
      ST_IGNORE = 4'h9
   } scsp_state_t;

endpackage

/* File: core/scsp_sync.sv */
// Purpose: Two-stage synchroniser for the serial pins and straps
// Assumes: Inputs are asynchronous to clk
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps

module scsp_sync
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] d,
   output logic      [3:0] q
);

   logic [3:0] meta_reg;
   logic [3:0] q_reg;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_reg <= 4'hF;
         q_reg    <= 4'hF;
      end
      else
      begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule // scsp_sync

/* File: core/scsp_ee_timer.sv */
// Purpose: EEPROM write-cycle busy timer
// Assumes: start is a one-cycle pulse on clk
// Notes:   A start while busy is ignored; the cycle is not restarted
`timescale 1ns/1ps

module scsp_ee_timer
   import scsp_pkg::*;
#(
   parameter int unsigned CYCLES = EE_WRITE_CYCLES
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      busy
);

   logic [EE_CNT_W-1:0] cnt_reg;
   logic                busy_reg;
   wire                 last_w = (cnt_reg == EE_CNT_W'(CYCLES - 1));

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
      end
      else if (start && !busy_reg)
      begin
         cnt_reg  <= '0;
         busy_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
         cnt_reg  <= cnt_reg + 1'b1;
         busy_reg <= !last_w;
      end
   end

   assign busy = busy_reg;

endmodule // scsp_ee_timer

/* File: core/scsp_top.sv */
// Purpose: Two-wire configuration slave port with register bank and EEPROM image
// Assumes: scl is the master's clock; sda_in is the resolved bus level
// Notes:   Byte shifting runs on scl; protocol decisions run on clk
`timescale 1ns/1ps

module scsp_top
   import scsp_pkg::*;
#(
   parameter int unsigned EE_WR_CYC = EE_WRITE_CYCLES
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         scl,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe,
   input  wire logic         addr_strap_low,
   input  wire logic         addr_strap_high,
   input  wire logic         reboot_busy,
   output logic              reboot_req,
   output logic              ee_busy,
   output logic              cfg_lock,
   output logic [159:0]      cfg_regs
);

   ////////////////////////////////////////////////////////////////////////////////
   // Link side: shift register clocked by the serial clock

   logic [7:0] shift_reg;

   // Sampled on the rising serial edge; read on clk only after a synced rise,
   // while the master cannot clock it again for most of a bit period
   always_ff @(posedge scl)
   begin
      shift_reg <= {shift_reg[6:0], sda_in};
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and bus events

   logic [3:0] sync_q;
   logic       scl_q_reg;
   logic       sda_q_reg;
   logic       start_hi_reg;

   scsp_sync u_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({scl, sda_in, addr_strap_high, addr_strap_low}),
      .q     (sync_q)
   );

   wire scl_s    = sync_q[3];
   wire sda_s    = sync_q[2];
   wire strap_hi = sync_q[1];
   wire strap_lo = sync_q[0];
   wire scl_rise = scl_s && !scl_q_reg;
   wire scl_fall = !scl_s && scl_q_reg;
   wire start_ev = scl_s && scl_q_reg && sda_q_reg && !sda_s;
   wire stop_raw = scl_s && scl_q_reg && !sda_q_reg && sda_s;
   wire stop_ev  = stop_raw && !start_hi_reg;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         scl_q_reg    <= 1'b1;
         sda_q_reg    <= 1'b1;
         start_hi_reg <= 1'b0;
      end
      else
      begin
         scl_q_reg    <= scl_s;
         sda_q_reg    <= sda_s;
         start_hi_reg <= start_ev || (start_hi_reg && !scl_fall);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Storage and address helpers

   function automatic logic in_reg(input logic [7:0] a);
      return (a >= REG_FIRST) && (a <= REG_LAST);
   endfunction

   function automatic logic in_ee(input logic [7:0] a);
      return (a >= EE_FIRST) && (a <= EE_LAST);
   endfunction

   // Saturates at the last location of the region the pointer is in
   function automatic logic [7:0] next_ptr(input logic [7:0] a);
      return (a == REG_LAST || a == EE_LAST) ? a : a + 8'h01;
   endfunction

   function automatic logic [4:0] mem_idx(input logic [7:0] a);
      return in_ee(a) ? 5'(a - EE_FIRST) : a[4:0];
   endfunction

   logic [7:0]  bank_reg [BANK_DEPTH];
   logic [7:0]  ee_reg   [BANK_DEPTH];
   scsp_state_t state_reg;
   scsp_state_t state_next;
   logic [3:0]  bit_cnt_reg;
   logic        ack_reg;
   logic        ack_next;
   logic [7:0]  ptr_reg;
   logic [7:0]  ptr_next;
   logic [4:0]  cnt_reg;
   logic [4:0]  cnt_next;
   logic [7:0]  tx_reg;
   logic [7:0]  tx_next;
   logic        sda_oe_reg;
   logic        sda_out_reg;
   logic        reboot_reg;
   logic        reboot_next;
   logic        wr_en;
   logic [7:0]  wr_addr;

   wire [7:0] rx_byte   = shift_reg;
   wire       byte_done = scl_rise && (bit_cnt_reg == BIT_LAST_DATA);
   wire       ack_rise  = scl_rise && (bit_cnt_reg == BIT_ACK);
   wire       busy      = reboot_busy || ee_busy;
   wire       lock      = bank_reg[REG_LAST[4:0]][LOCK_BIT];
   wire       tx_mode   = (state_reg == ST_RDCNT) || (state_reg == ST_RDDATA);
   wire       addr_hit  = (rx_byte[7:4] == DEV_TYPE_CODE) &&
                          (rx_byte[3] == strap_hi) && (rx_byte[2] == strap_lo);
   wire       ptr_ok    = in_reg(rx_byte) || in_ee(rx_byte);
   wire       cnt_ok    = (rx_byte >= BLK_MIN) && (rx_byte <= BLK_MAX);
   wire [7:0] rd_byte   = in_reg(ptr_reg) ? bank_reg[mem_idx(ptr_reg)] :
                          in_ee(ptr_reg)  ? ee_reg[mem_idx(ptr_reg)] : 8'h00;
   // Register 13h stays writable under lock so the lock can be released
   wire       wr_bank   = wr_en && in_reg(wr_addr) && (!lock || wr_addr == REG_LAST);
   wire       wr_ee     = wr_en && in_ee(wr_addr) && !lock && !ee_busy;
   wire [2:0] tx_bit    = 3'h7 - bit_cnt_reg[2:0];
   wire       drive_low = (bit_cnt_reg == BIT_ACK) ? ack_reg : (tx_mode && !tx_reg[tx_bit]);

   scsp_ee_timer #(.CYCLES(EE_WR_CYC)) u_ee_timer
   (
      .clk   (clk),
      .rst_n (rst_n),
      .start (wr_ee),
      .busy  (ee_busy)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Protocol decisions, taken once per byte

   always_comb
   begin
      state_next  = state_reg;
      ack_next    = ack_reg;
      ptr_next    = ptr_reg;
      cnt_next    = cnt_reg;
      tx_next     = tx_reg;
      reboot_next = 1'b0;
      wr_en       = 1'b0;
      wr_addr     = ptr_reg;
      if (start_ev)
      begin
         state_next = ST_ADDR;
         ack_next   = 1'b0;
      end
      else if (stop_ev)
      begin
         state_next = ST_IDLE;
         ack_next   = 1'b0;
      end
      else if (byte_done)
      begin
         ack_next = 1'b0;
         unique case (state_reg)
            ST_ADDR:
            begin
               state_next = ST_IGNORE;
               if (addr_hit && !busy)
               begin
                  ack_next = 1'b1;
                  if (rx_byte[0])
                  begin
                     state_next = ST_RDCNT;
                     tx_next    = BLK_READ_COUNT;
                  end
                  else
                     state_next = ST_CMD;
               end
            end
            ST_CMD:
            begin
               state_next = ST_IGNORE;
               if (!busy)
               begin
                  if (ptr_ok)
                  begin
                     ack_next   = 1'b1;
                     ptr_next   = rx_byte;
                     state_next = ST_DATA1;
                  end
                  else if (rx_byte == CMD_BLK_WRITE)
                  begin
                     ack_next   = 1'b1;
                     state_next = ST_BCNT;
                  end
                  else if (rx_byte == CMD_BLK_PREP || rx_byte == CMD_BLK_READ)
                     ack_next = 1'b1;
                  else if (rx_byte == CMD_REBOOT)
                  begin
                     ack_next    = 1'b1;
                     reboot_next = 1'b1;
                  end
               end
            end
            ST_DATA1:
            begin
               ack_next   = 1'b1;
               wr_en      = 1'b1;
               state_next = ST_DATA2;
            end
            ST_DATA2:
            begin
               ack_next   = 1'b1;
               wr_en      = 1'b1;
               wr_addr    = next_ptr(ptr_reg);
               state_next = ST_IGNORE;
            end
            ST_BCNT:
            begin
               state_next = ST_IGNORE;
               if (cnt_ok)
               begin
                  ack_next   = 1'b1;
                  cnt_next   = rx_byte[4:0];
                  state_next = ST_BDATA;
               end
            end
            ST_BDATA:
            begin
               ack_next = 1'b1;
               wr_en    = 1'b1;
               ptr_next = next_ptr(ptr_reg);
               cnt_next = cnt_reg - 5'h01;
               if (cnt_reg == 5'h01)
                  state_next = ST_IGNORE;
            end
            ST_IDLE, ST_RDCNT, ST_RDDATA, ST_IGNORE:
            begin
            end
         endcase
      end
      else if (ack_rise && tx_mode && !ack_reg)
      begin
         if (!sda_s)
         begin
            tx_next    = rd_byte;
            ptr_next   = next_ptr(ptr_reg);
            state_next = ST_RDDATA;
         end
         else
            state_next = ST_IGNORE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Protocol registers

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_reg   <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         ack_reg     <= 1'b0;
         ptr_reg     <= REG_FIRST;
         cnt_reg     <= 5'h00;
         tx_reg      <= 8'h00;
         reboot_reg  <= 1'b0;
      end
      else
      begin
         state_reg  <= state_next;
         ack_reg    <= ack_next;
         ptr_reg    <= ptr_next;
         cnt_reg    <= cnt_next;
         tx_reg     <= tx_next;
         reboot_reg <= reboot_next;
         if (start_ev || stop_ev)
            bit_cnt_reg <= 4'h0;
         else if (scl_rise)
            bit_cnt_reg <= (bit_cnt_reg == BIT_ACK) ? 4'h0 : bit_cnt_reg + 4'h1;
      end
   end

   // Output is driven only on a synced falling edge, so the line moves while low; a start or stop releases it at once
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sda_oe_reg  <= 1'b0;
         sda_out_reg <= 1'b0;
      end
      else if (start_ev || stop_ev)
         sda_oe_reg <= 1'b0;
      else if (scl_fall)
         sda_oe_reg <= drive_low;
   end

   // Nonvolatile image is cleared at reset here; power-up load lives elsewhere
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < BANK_DEPTH; i++)
         begin
            bank_reg[i] <= BANK_RESET;
            ee_reg[i]   <= BANK_RESET;
         end
      end
      else
      begin
         if (wr_bank)
            bank_reg[mem_idx(wr_addr)] <= rx_byte;
         if (wr_ee)
            ee_reg[mem_idx(wr_addr)] <= rx_byte;
      end
   end

   assign sda_out    = sda_out_reg;
   assign sda_oe     = sda_oe_reg;
   assign reboot_req = reboot_reg;
   assign cfg_lock   = lock;

   for (genvar g = 0; g < BANK_DEPTH; g++)
   begin : g_regs
      assign cfg_regs[g*8 +: 8] = bank_reg[g];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_ACK_DRIVE: assert property (
      (scl_fall && bit_cnt_reg == BIT_ACK && ack_reg && !start_ev && !stop_ev) |=> sda_oe)
      else $error("ack not driven in ninth clock");
   AST_TX_RELEASE: assert property (
      (scl_fall && tx_mode && bit_cnt_reg == BIT_ACK && !ack_reg) |=> !sda_oe)
      else $error("data line held during master ack");
   AST_BUSY_NACK: assert property (
      (byte_done && state_reg == ST_ADDR && busy && !start_ev && !stop_ev)
      |=> !ack_reg && state_reg == ST_IGNORE)
      else $error("address acked while busy");
   AST_ADDR_MISS: assert property (
      (byte_done && state_reg == ST_ADDR && !addr_hit && !start_ev && !stop_ev) |=> !ack_reg)
      else $error("foreign address acked");
   AST_PTR_KEEP: assert property (
      (stop_ev && state_reg == ST_CMD) |=> ptr_reg == $past(ptr_reg))
      else $error("pointer moved on early stop");
   AST_REBOOT: assert property (
      (byte_done && state_reg == ST_CMD && rx_byte == CMD_REBOOT && !busy
       && !start_ev && !stop_ev) |=> reboot_req ##1 !reboot_req)
      else $error("reboot pulse missing");
   AST_BAD_CMD: assert property (
      (byte_done && state_reg == ST_CMD && !ptr_ok && rx_byte < CMD_BLK_WRITE
       && !start_ev && !stop_ev) |=> !ack_reg)
      else $error("illegal pointer acked");
   AST_SATURATE: assert property (
      (byte_done && state_reg == ST_BDATA && ptr_reg == REG_LAST && !start_ev && !stop_ev)
      |=> ptr_reg == REG_LAST)
      else $error("pointer passed last bank register");
   AST_LOCK_EE: assert property (
      (wr_en && in_ee(wr_addr) && lock) |=> $stable(ee_busy) || !ee_busy)
      else $error("EEPROM write started under lock");
   AST_RD_COUNT: assert property (
      (byte_done && state_reg == ST_ADDR && addr_hit && rx_byte[0] && !busy
       && !start_ev && !stop_ev) |=> tx_reg == BLK_READ_COUNT && state_reg == ST_RDCNT)
      else $error("block read count not loaded");
   AST_OE_SCL_LOW: assert property (
      (sda_oe && !$past(sda_oe)) |-> !scl_q_reg)
      else $error("data driven while clock high");

   COV_BLOCK_WRITE: cover property (byte_done && state_reg == ST_BDATA && cnt_reg == 5'h01);
   COV_BLOCK_READ:  cover property (ack_rise && state_reg == ST_RDDATA && !sda_s);
   COV_REBOOT:      cover property (reboot_req);
   COV_WORD_WRITE:  cover property (byte_done && state_reg == ST_DATA2);

endmodule // scsp_top

/* File: test/scsp_bus_master.sv */
// Purpose: Two-wire bus master model that drives the serial port
// Assumes: Data line has a pull-up; 80 ns bit period
// Notes:   Clock stands high between frames
`timescale 1ns/1ps

module scsp_bus_master
(
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   initial
   begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start or repeated start; data released first so the device has let go
   task automatic start();
      sda_pull = 1'b0;
      #40 scl = 1'b1;
      #40 sda_pull = 1'b1;
      #40 scl = 1'b0;
      #20;
   endtask

   task automatic put_bit(input logic b);
      sda_pull = ~b;
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #20;
   endtask

   task automatic get_bit(output logic b);
      sda_pull = 1'b0;
      #20 scl = 1'b1;
      #20 b = sda;
      #20 scl = 1'b0;
      #20;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         put_bit(d[i]);
      get_bit(s);
      ack = ~s;
   endtask

   // Master answers every byte it reads; a NACK ends the read
   task automatic rd_byte(output logic [7:0] d, input logic ack);
      for (int i = 7; i >= 0; i--)
         get_bit(d[i]);
      put_bit(~ack);
   endtask

   task automatic stop();
      sda_pull = 1'b1;
      #20 scl = 1'b1;
      #40 sda_pull = 1'b0;
      #40;
   endtask
endmodule // scsp_bus_master

/* File: test/testbench.sv */
// Purpose: Self-checking bench of the serial configuration slave port
// Assumes: Straps high/low give write address A8h
// Notes:   EEPROM write cycle shortened to 500 clocks
`timescale 1ns/1ps

module testbench;
   import scsp_pkg::*;

   localparam logic [7:0] AW = 8'hA8;
   localparam logic [7:0] AR = 8'hA9;
   typedef struct packed {logic [7:0] cmd; logic [7:0] data; logic ack; logic ee;} scsp_row_t;

   logic         clk         = 1'b0;
   logic         rst_n       = 1'b0;
   logic         strap_h     = 1'b1;
   logic         strap_l     = 1'b0;
   logic         reboot_busy = 1'b0;
   logic         rb_seen     = 1'b0;
   logic         scl, sda_pull, sda_w, sda_out, sda_oe, reboot_req, ee_busy, cfg_lock;
   logic [159:0] cfg_regs;
   logic [159:0] shadow      = '0;
   int           n_mismatch  = 0;
   int           checks_done = 0;
   scsp_row_t    rows[8]     = '{'{8'h05, 8'hAB, 1, 0}, '{8'h00, 8'h11, 1, 0},
                                 '{8'h12, 8'h5A, 1, 0}, '{8'h14, 8'h77, 0, 0},
                                 '{8'h1F, 8'h00, 0, 0}, '{8'h34, 8'h00, 0, 0},
                                 '{8'h20, 8'h3C, 1, 1}, '{8'h33, 8'hC3, 1, 1}};
   logic [8:0]   adrs[5]     = '{{8'h58, 1'b0}, {8'hA4, 1'b0}, {8'hAC, 1'b0},
                                 {8'hA0, 1'b0}, {8'hAA, 1'b1}};

   always #4 clk = ~clk;
   // Pull-up: the line is low only while someone pulls it
   assign sda_w = ~(sda_oe | sda_pull);
   always @(posedge clk)
      if (reboot_req === 1'b1)
         rb_seen <= 1'b1;

   scsp_top #(.EE_WR_CYC(500)) scsp_top_i
   (
      .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe(sda_oe), .addr_strap_low(strap_l), .addr_strap_high(strap_h),
      .reboot_busy(reboot_busy), .reboot_req(reboot_req), .ee_busy(ee_busy),
      .cfg_lock(cfg_lock), .cfg_regs(cfg_regs)
   );

   scsp_bus_master scsp_bus_master_i (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [159:0] seen, input logic [159:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic [7:0] b, input logic exp);
      logic a;
      scsp_bus_master_i.wr_byte(b, a);
      chk(a, exp);
   endtask

   task automatic rb(input logic [7:0] exp, input logic ack);
      logic [7:0] d;
      scsp_bus_master_i.rd_byte(d, ack);
      chk(d, exp);
   endtask

   task automatic wr2(input logic [7:0] c, input logic [7:0] d);
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      wb(c, 1'b1);
      wb(d, 1'b1);
      scsp_bus_master_i.stop();
      repeat (4) @(posedge clk);
   endtask

   task automatic ee_idle();
      int n;
      n = 0;
      while (ee_busy !== 1'b0 && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      chk(n < 1000, 1'b1);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(cfg_regs, 160'h0);
      chk({cfg_lock, ee_busy, sda_oe, sda_out, rb_seen}, 5'h00);
      repeat (5) @(posedge clk);
      foreach (adrs[i])
      begin
         scsp_bus_master_i.start();
         wb(adrs[i][8:1], adrs[i][0]);
         scsp_bus_master_i.stop();
      end
      foreach (rows[i])
      begin
         scsp_bus_master_i.start();
         wb(AW, 1'b1);
         wb(rows[i].cmd, rows[i].ack);
         if (rows[i].ack)
            wb(rows[i].data, 1'b1);
         scsp_bus_master_i.stop();
         if (rows[i].ack && !rows[i].ee)
            shadow[8 * rows[i].cmd +: 8] = rows[i].data;
         repeat (4) @(posedge clk);
         chk(cfg_regs, shadow);
         chk(ee_busy, rows[i].ee);
         if (rows[i].ee)
         begin
            scsp_bus_master_i.start();
            wb(AW, 1'b0);
            scsp_bus_master_i.stop();
            ee_idle();
         end
      end
      // Write word, then a second write after a repeated start
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      wb(8'h06, 1'b1);
      wb(8'h31, 1'b1);
      wb(8'h32, 1'b1);
      scsp_bus_master_i.start();
      wr2(8'h08, 8'h44);
      shadow[48 +: 24] = 24'h443231;
      chk(cfg_regs, shadow);
      // Pointer set by send byte, then block write runs into 13h and saturates there
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      wb(8'h11, 1'b1);
      scsp_bus_master_i.stop();
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      wb(CMD_BLK_WRITE, 1'b1);
      wb(8'h04, 1'b1);
      for (int i = 1; i <= 4; i++)
         wb(8'(2 * i), 1'b1);
      scsp_bus_master_i.stop();
      repeat (4) @(posedge clk);
      shadow[136 +: 24] = 24'h080402;
      chk(cfg_regs, shadow);
      for (int i = 0; i < 2; i++)
      begin
         scsp_bus_master_i.start();
         wb(AW, 1'b1);
         wb(CMD_BLK_WRITE, 1'b1);
         wb(i ? 8'h11 : 8'h00, 1'b0);
         scsp_bus_master_i.stop();
      end
      // Pointer 11h, an empty write frame, then block read ended by NACK
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      wb(8'h11, 1'b1);
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      scsp_bus_master_i.stop();
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      wb(CMD_BLK_READ, 1'b1);
      scsp_bus_master_i.start();
      wb(AR, 1'b1);
      rb(BLK_READ_COUNT, 1'b1);
      rb(8'h02, 1'b1);
      rb(8'h04, 1'b1);
      rb(8'h08, 1'b0);
      repeat (8) @(posedge clk)
         chk(sda_oe, 1'b0);
      scsp_bus_master_i.stop();
      // Busy core: address and block read command refused
      @(posedge clk);
      reboot_busy <= 1'b1;
      scsp_bus_master_i.start();
      wb(AW, 1'b0);
      scsp_bus_master_i.stop();
      @(posedge clk);
      reboot_busy <= 1'b0;
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      @(posedge clk);
      reboot_busy <= 1'b1;
      wb(CMD_BLK_READ, 1'b0);
      scsp_bus_master_i.stop();
      @(posedge clk);
      reboot_busy <= 1'b0;
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      wb(CMD_BLK_PREP, 1'b1);
      scsp_bus_master_i.stop();
      chk(rb_seen, 1'b0);
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      wb(CMD_REBOOT, 1'b1);
      scsp_bus_master_i.stop();
      chk(rb_seen, 1'b1);
      // Lock set: bank and EEPROM writes dropped, 13h stays writable
      wr2(8'h13, 8'h01);
      chk(cfg_lock, 1'b1);
      wr2(8'h05, 8'h99);
      shadow[152 +: 8] = 8'h01;
      chk(cfg_regs, shadow);
      wr2(8'h21, 8'h55);
      chk(ee_busy, 1'b0);
      wr2(8'h13, 8'h00);
      chk(cfg_lock, 1'b0);
      // EEPROM image read back: 20h kept, 21h untouched by the locked write
      scsp_bus_master_i.start();
      wb(AW, 1'b1);
      wb(EE_FIRST, 1'b1);
      scsp_bus_master_i.start();
      wb(AR, 1'b1);
      rb(BLK_READ_COUNT, 1'b1);
      rb(8'h3C, 1'b1);
      rb(8'h00, 1'b0);
      scsp_bus_master_i.stop();
      print_verdict();
   end
endmodule // testbench
